// File: hw/sample_fifo_with_irq_pins.v
// Operation
// - Buffer holds 512 entries of samples.
// - Mode 0b00 stores nothing, clears contents.
// - Mode 0b11 fills then stops storing.
// - Mode 0b01 keeps newest, drops oldest.
// - Watermark flag when count reaches programmed level.
// - Mode 0b10 streams, then freezes after trigger.
// - Trigger re-arms after activity cleared, buffer drained.
// - Read port address never advances; pops.
// - Upper byte returned first, then lower.
// - 12-bit data left justified; bit0 series start.
// - Pin is OR of routed sources.
// - Unrouted or reset pin is released.
// - Active high; polarity bit makes low.
// - Event status read clears activity, inactivity, except in default mode with timer zero.
// - Event status read clears motion warning.
// - Data register read clears sample ready.
// - Non-empty and overrun clear on drain plus status read; watermark on status read once count is below level.
// - Watermark while count at least programmed count.
// - Non-empty when readable; triggered after capture.
// - Overrun on replaced or refused sample.
`include "sample_fifo_map.vh"

module sample_fifo_with_irq_pins #(
	parameter DEPTH = 512,
	parameter AW = 9
) (
	clk_sys,
	sys_rst,
	clk_en,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	sample_valid,
	sample_data,
	activity_evt,
	inactivity_evt,
	motion_warn_evt,
	measure_en,
	act_default_mode,
	act_timer_zero,
	inactivity_flag_timer_zero,
	irq_pin_a_o,
	irq_pin_a_oe,
	irq_pin_b_o,
	irq_pin_b_oe
);
	input wire clk_sys;
	input wire sys_rst;
	input wire clk_en;
	input wire [7:0] reg_addr;
	input wire [7:0] reg_wdata;
	input wire reg_wr;
	input wire reg_rd;
	output wire [7:0] reg_rdata;
	input wire sample_valid;
	input wire [11:0] sample_data;
	input wire activity_evt;
	input wire inactivity_evt;
	input wire motion_warn_evt;
	input wire measure_en;
	input wire act_default_mode;
	input wire act_timer_zero;
	input wire inactivity_flag_timer_zero;
	output wire irq_pin_a_o;
	output wire irq_pin_a_oe;
	output wire irq_pin_b_o;
	output wire irq_pin_b_oe;

	// Register file
	reg [7:0] watermark_q; // Low bits of programmed count
	reg [7:0] ctl_q; // Buffer control
	reg [7:0] route_a_q; // Pin A routing
	reg [7:0] route_b_q; // Pin B routing
	reg [7:0] rdata_q; // Registered read answer
	reg [11:0] last_sample_q; // Newest sample for data registers

	// Buffer state
	reg [AW-1:0] wr_ptr_q;
	reg [AW-1:0] rd_ptr_q;
	reg [AW:0] count_q; // 0 to DEPTH
	reg byte_sel_q; // Low byte is next
	reg [7:0] hold_lo_q; // Low byte of word being read
	reg first_q; // Next stored entry starts a series
	reg trig_q; // Trigger captured
	reg [AW:0] post_cnt_q; // Samples stored after trigger

	// Flags
	reg dready_q;
	reg nonempty_q;
	reg wmark_q;
	reg ovr_q;
	reg act_q;
	reg inactivity_flag_q;
	reg motion_q;

	wire [15:0] mem_rd_data;
	wire [1:0] mode = ctl_q[`CTL_MODE_MSB:`CTL_MODE_LSB];
	wire [8:0] wm_prog = {ctl_q[`CTL_COUNT_MSB], watermark_q};
	wire [AW+9:0] wm_level = {{(AW+1){1'b0}}, wm_prog}; // Widened so no count bit is lost

	// Address match helper
	function hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	// Access strobes
	wire rd_port = reg_rd && hit(reg_addr, `ADDR_READ_PORT);
	wire rd_status = reg_rd && hit(reg_addr, `ADDR_MAIN_STATUS);
	wire rd_event = reg_rd && hit(reg_addr, `ADDR_EVENT_STATUS);
	wire rd_data = reg_rd && (hit(reg_addr, `ADDR_DATA_HI) || hit(reg_addr, `ADDR_DATA_LO));
	wire wr_ctl = reg_wr && hit(reg_addr, `ADDR_BUF_CONTROL);

	// Buffer conditions
	wire full = (count_q == DEPTH[AW:0]);
	wire frozen = trig_q && ({9'h000, post_cnt_q} >= wm_level);
	wire visible = (count_q != {(AW+1){1'b0}})
		&& ((mode != `MODE_TRIGGERED) || trig_q);
	wire enabled = (mode != `MODE_DISABLED);
	wire refuse_oldest = (mode == `MODE_OLDEST) && full;
	wire push = sample_valid && enabled && !refuse_oldest
		&& !((mode == `MODE_TRIGGERED) && frozen);
	wire drop_old = push && full;
	wire ovr_evt = (drop_old || (sample_valid && refuse_oldest));
	wire pop = rd_port && byte_sel_q && visible;
	wire rd_adv = pop || drop_old;
	wire wm_cond = ({9'h000, count_q} >= wm_level);
	wire rearm = frozen && !act_q && (count_q == {(AW+1){1'b0}});
	wire sticky_act = act_default_mode && act_timer_zero;
	wire sticky_inactivity_flag = act_default_mode && inactivity_flag_timer_zero;

	// Entry: data in 15:4, series start in bit 0
	wire [15:0] entry = {sample_data, 3'h0, first_q};

	// Source vector shared by status and pins
	wire [`SRC_COUNT-1:0] sources = {motion_q, inactivity_flag_q, act_q, ovr_q,
		wmark_q, nonempty_q, dready_q};

	// Entry memory
	sample_mem #(
		.WIDTH(16),
		.DEPTH(DEPTH),
		.AW(AW)
	) u_mem (
		.clk_sys(clk_sys),
		.clk_en(clk_en),
		.wr_en(push),
		.wr_addr(wr_ptr_q),
		.wr_data(entry),
		.rd_addr(rd_ptr_q),
		.rd_data(mem_rd_data)
	);

	// Register writes
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			watermark_q <= `RST_WATERMARK;
			ctl_q <= `RST_BUF_CONTROL;
			route_a_q <= `RST_ROUTING;
			route_b_q <= `RST_ROUTING;
		end else if (clk_en && reg_wr) begin
			// Decode target register
			case (reg_addr)
				`ADDR_WATERMARK: watermark_q <= reg_wdata;
				`ADDR_BUF_CONTROL: ctl_q <= reg_wdata;
				`ADDR_PIN_A_ROUTING: route_a_q <= reg_wdata;
				`ADDR_PIN_B_ROUTING: route_b_q <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Pointers, count, trigger
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
			first_q <= 1'b1;
			trig_q <= 1'b0;
			post_cnt_q <= {(AW+1){1'b0}};
		end else if (clk_en) begin
			if (!enabled) begin
				// Disabled: discard everything
				wr_ptr_q <= {AW{1'b0}};
				rd_ptr_q <= {AW{1'b0}};
				count_q <= {(AW+1){1'b0}};
				first_q <= 1'b1;
				trig_q <= 1'b0;
				post_cnt_q <= {(AW+1){1'b0}};
			end else begin
				// Write side
				if (push) begin
					wr_ptr_q <= wr_ptr_q + 1'b1;
					first_q <= 1'b0;
				end
				// Read side; a push into a full buffer drops its oldest entry
				if (rd_adv) begin
					rd_ptr_q <= rd_ptr_q + 1'b1;
				end
				// Occupancy
				if (push && !rd_adv) begin
					count_q <= count_q + 1'b1;
				end else if (!push && rd_adv) begin
					count_q <= count_q - 1'b1;
				end
				// Trigger capture and re-arm
				if (rearm) begin
					trig_q <= 1'b0;
					post_cnt_q <= {(AW+1){1'b0}};
				end else if (mode == `MODE_TRIGGERED && !trig_q && activity_evt) begin
					trig_q <= 1'b1;
				end else if (trig_q && push) begin
					post_cnt_q <= post_cnt_q + 1'b1;
				end
			end
		end
	end

	// Buffer flags; an event in the clearing cycle wins
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			nonempty_q <= 1'b0;
			wmark_q <= 1'b0;
			ovr_q <= 1'b0;
		end else if (clk_en) begin
			nonempty_q <= visible || (nonempty_q && !rd_status);
			wmark_q <= wm_cond || (wmark_q && !rd_status);
			if (!enabled) begin
				ovr_q <= 1'b0;
			end else begin
				ovr_q <= ovr_evt || (ovr_q && !(rd_status && !visible));
			end
		end
	end

	// Event flags
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			act_q <= 1'b0;
			inactivity_flag_q <= 1'b0;
			motion_q <= 1'b0;
			dready_q <= 1'b0;
		end else if (clk_en) begin
			// Standby clears latched activity states
			if (!measure_en) begin
				act_q <= 1'b0;
				inactivity_flag_q <= 1'b0;
			end else begin
				act_q <= activity_evt || (act_q && !(rd_event && !sticky_act));
				inactivity_flag_q <= inactivity_evt
					|| (inactivity_flag_q && !(rd_event && !sticky_inactivity_flag));
			end
			motion_q <= motion_warn_evt || (motion_q && !rd_event);
			dready_q <= sample_valid || (dready_q && !rd_data);
		end
	end

	// Newest sample for the data registers
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			last_sample_q <= 12'h000;
		end else if (clk_en && sample_valid) begin
			last_sample_q <= sample_data;
		end
	end

	// Read port byte sequencing
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			byte_sel_q <= 1'b0;
			hold_lo_q <= 8'h00;
		end else if (clk_en) begin
			if (!enabled || wr_ctl) begin
				byte_sel_q <= 1'b0;
			end else if (rd_port && visible) begin
				// High byte read latches the low byte
				if (!byte_sel_q) begin
					hold_lo_q <= mem_rd_data[7:0];
				end
				byte_sel_q <= !byte_sel_q;
			end
		end
	end

	// Registered read answer
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q <= 8'h00;
		end else if (clk_en && reg_rd) begin
			case (reg_addr)
				`ADDR_MAIN_STATUS: rdata_q <= {2'b00, sources[`SRC_MOTION_WARN-1:0]};
				`ADDR_EVENT_STATUS: rdata_q <= {5'h00, inactivity_flag_q, act_q, motion_q};
				`ADDR_DATA_HI: rdata_q <= last_sample_q[11:4];
				`ADDR_DATA_LO: rdata_q <= {last_sample_q[3:0], 4'h0};
				`ADDR_WATERMARK: rdata_q <= watermark_q;
				`ADDR_BUF_CONTROL: rdata_q <= ctl_q;
				`ADDR_PIN_A_ROUTING: rdata_q <= route_a_q;
				`ADDR_PIN_B_ROUTING: rdata_q <= route_b_q;
				`ADDR_READ_PORT: begin
					// Empty port answers zero
					if (!visible) begin
						rdata_q <= 8'h00;
					end else if (byte_sel_q) begin
						rdata_q <= hold_lo_q;
					end else begin
						rdata_q <= mem_rd_data[15:8];
					end
				end
				default: rdata_q <= 8'h00;
			endcase
		end
	end

	assign reg_rdata = rdata_q;

	// Interrupt pins
	irq_pin_drive u_pin_a (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.sources(sources),
		.routing(route_a_q),
		.pin_o(irq_pin_a_o),
		.pin_oe(irq_pin_a_oe)
	);

	irq_pin_drive u_pin_b (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.sources(sources),
		.routing(route_b_q),
		.pin_o(irq_pin_b_o),
		.pin_oe(irq_pin_b_oe)
	);
endmodule

// File: pkg/sample_fifo_map.vh
`ifndef SAMPLE_FIFO_MAP_VH
`define SAMPLE_FIFO_MAP_VH

// Register offsets
`define ADDR_MAIN_STATUS 8'h04
`define ADDR_EVENT_STATUS 8'h05
`define ADDR_DATA_HI 8'h08
`define ADDR_DATA_LO 8'h09
`define ADDR_WATERMARK 8'h39
`define ADDR_BUF_CONTROL 8'h3A
`define ADDR_READ_PORT 8'h3B
`define ADDR_PIN_A_ROUTING 8'h3C
`define ADDR_PIN_B_ROUTING 8'h3D

// Reset values
`define RST_WATERMARK 8'h80
`define RST_BUF_CONTROL 8'h00
`define RST_ROUTING 8'h00

// Buffer control fields
`define CTL_COUNT_MSB 0
`define CTL_MODE_LSB 1
`define CTL_MODE_MSB 2

// Buffer modes
`define MODE_DISABLED 2'h0
`define MODE_STREAM 2'h1
`define MODE_TRIGGERED 2'h2
`define MODE_OLDEST 2'h3

// Status source positions, shared by routing registers and, for positions 0 to 5 only, main status
`define SRC_DATA_READY 0
`define SRC_NONEMPTY 1
`define SRC_WATERMARK 2
`define SRC_OVERRUN 3
`define SRC_ACTIVITY 4
`define SRC_INACTIVITY 5
`define SRC_MOTION_WARN 6
`define SRC_COUNT 7
`define ROUTE_POLARITY_LOW 7

// Event status fields
`define EVT_MOTION_WARN 0
`define EVT_ACTIVITY 1
`define EVT_INACTIVITY 2

// Entry layout
`define ENTRY_SERIES_START 0
`define ENTRY_DATA_LSB 4

`endif

// File: hw/sample_mem.v
module sample_mem #(
	parameter WIDTH = 16,
	parameter DEPTH = 512,
	parameter AW = 9
) (
	clk_sys,
	clk_en,
	wr_en,
	wr_addr,
	wr_data,
	rd_addr,
	rd_data
);
	input wire clk_sys;
	input wire clk_en;
	input wire wr_en;
	input wire [AW-1:0] wr_addr;
	input wire [WIDTH-1:0] wr_data;
	input wire [AW-1:0] rd_addr;
	output reg [WIDTH-1:0] rd_data;

	// Entry storage
	reg [WIDTH-1:0] mem [0:DEPTH-1];

	// Write port and registered read port
	always @(posedge clk_sys) begin
		if (clk_en) begin
			if (wr_en) begin
				mem[wr_addr] <= wr_data;
			end
			rd_data <= mem[rd_addr];
		end
	end
endmodule

// File: hw/irq_pin_drive.v
`include "sample_fifo_map.vh"

module irq_pin_drive (
	clk_sys,
	sys_rst,
	clk_en,
	sources,
	routing,
	pin_o,
	pin_oe
);
	input wire clk_sys;
	input wire sys_rst;
	input wire clk_en;
	input wire [`SRC_COUNT-1:0] sources;
	input wire [7:0] routing;
	output reg pin_o;
	output reg pin_oe;

	// OR of routed sources, polarity applied, released when nothing routed
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pin_o <= 1'b0;
			pin_oe <= 1'b0;
		end else if (clk_en) begin
			pin_oe <= |routing[`SRC_COUNT-1:0];
			pin_o <= (|(sources & routing[`SRC_COUNT-1:0]))
				^ routing[`ROUTE_POLARITY_LOW];
		end
	end
endmodule

// File: dv/fifo_irq_checker_assertions.sv
module fifo_irq_checker (
	input wire clk_sys,
	input wire sys_rst,
	input wire clk_en,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire sample_valid,
	input wire activity_evt,
	input wire motion_warn_evt,
	input wire act_default_mode,
	input wire act_timer_zero,
	input wire irq_pin_a_o,
	input wire irq_pin_a_oe,
	input wire irq_pin_b_o,
	input wire irq_pin_b_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rt_a_q; // Routing A as written
	logic [7:0] rt_b_q; // Routing B as written
	logic [1:0] mode_q; // Buffer mode as written
	// Shadow of host writes
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rt_a_q <= 8'h00;
			rt_b_q <= 8'h00;
			mode_q <= 2'h0;
		end else if (reg_wr && clk_en) begin
			if (reg_addr == 8'h3C) rt_a_q <= reg_wdata;
			if (reg_addr == 8'h3D) rt_b_q <= reg_wdata;
			if (reg_addr == 8'h3A) mode_q <= reg_wdata[2:1];
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// Read taken at one address
	sequence rd_at(a);
		reg_rd && clk_en && reg_addr == a;
	endsequence
	// Three cycles without new event or write
	sequence calm(ev);
		(!ev && !reg_wr && clk_en) [*3];
	endsequence
	hiz_after_reset_a: assert property ($fell(sys_rst) |-> !irq_pin_a_oe && !irq_pin_b_oe)
		else $error("pin driven after reset");
	route_oe_a_a: assert property ($past(clk_en) |-> irq_pin_a_oe == |($past(rt_a_q) & 8'h7F))
		else $error("pin a enable wrong");
	route_oe_b_a: assert property ($past(clk_en) |-> irq_pin_b_oe == |($past(rt_b_q) & 8'h7F))
		else $error("pin b enable wrong");
	ready_pin_a: assert property (sample_valid && clk_en && !reg_rd && !reg_wr && rt_a_q[6:0] == 7'h01
		##1 !reg_rd && !reg_wr && clk_en |=> irq_pin_a_o == !rt_a_q[7])
		else $error("pin a not active after sample");
	ready_clear_a: assert property (rd_at(8'h08) ##0 rt_a_q == 8'h01
		##0 calm(sample_valid) |=> !irq_pin_a_o) else $error("data ready not cleared");
	warn_clear_a: assert property (rd_at(8'h05) ##0 rt_b_q == 8'h40
		##0 calm(motion_warn_evt) |=> !irq_pin_b_o) else $error("motion warning not cleared");
	act_clear_a: assert property (rd_at(8'h05) ##0 rt_b_q == 8'h10 && !act_default_mode
		##0 calm(activity_evt) |=> !irq_pin_b_o) else $error("activity not cleared");
	off_read_zero_a: assert property (rd_at(8'h3B) ##0 mode_q == 2'h0
		&& $past(mode_q) == 2'h0 |=> reg_rdata == 8'h00)
		else $error("disabled buffer returned data");
	rdata_hold_a: assert property (!(reg_rd && clk_en) |=> $stable(reg_rdata))
		else $error("read data moved without read");
endmodule

bind sample_fifo_with_irq_pins fifo_irq_checker fifo_irq_checker_inst (.clk_sys, .sys_rst,
	.clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sample_valid, .activity_evt,
	.motion_warn_evt, .act_default_mode, .act_timer_zero, .irq_pin_a_o, .irq_pin_a_oe,
	.irq_pin_b_o, .irq_pin_b_oe);

// File: dv/sample_feeder.sv
module sample_feeder (
	input wire clk_sys,
	input wire sys_rst,
	input wire go,
	input wire [7:0] n_req,
	input wire [3:0] gap,
	output logic busy,
	output logic sample_valid,
	output logic [11:0] sample_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] left_q; // Samples still to send
	logic [3:0] wait_q; // Idle cycles before next
	logic [11:0] nxt_q; // Next sample value
	assign busy = left_q != 8'h00;
	// Burst of samples; data line flips between them
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			left_q <= 8'h00;
			wait_q <= 4'h0;
			nxt_q <= 12'h801;
			sample_valid <= 1'b0;
			sample_data <= 12'h000;
		end else if (go) begin
			left_q <= n_req;
			wait_q <= 4'h0;
		end else if (busy && wait_q == 4'h0) begin
			sample_valid <= 1'b1;
			sample_data <= nxt_q;
			nxt_q <= nxt_q + 12'h1A3;
			left_q <= left_q - 8'h01;
			wait_q <= gap;
		end else begin
			sample_valid <= 1'b0;
			sample_data <= ~sample_data;
			if (wait_q != 4'h0) wait_q <= wait_q - 4'h1;
		end
	end
endmodule

// File: dv/test_sample_fifo_with_irq_pins.sv
module test_sample_fifo_with_irq_pins;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, sys_rst, reg_wr, reg_rd, go, measure_en;
	logic activity_evt, motion_warn_evt, act_default_mode, act_timer_zero;
	logic [7:0] reg_addr, reg_wdata, n_req, d;
	logic [3:0] gap;
	logic [11:0] b, k, last_v;
	wire [7:0] reg_rdata;
	wire [11:0] sample_data;
	wire sample_valid, busy, irq_pin_a_o, irq_pin_a_oe, irq_pin_b_o, irq_pin_b_oe;
	int i, error_cnt, n_compared;
	sample_fifo_with_irq_pins #(.DEPTH(8), .AW(3)) sample_fifo_with_irq_pins_inst (.clk_sys,
		.sys_rst, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.sample_valid, .sample_data, .activity_evt, .inactivity_evt(1'b0), .motion_warn_evt,
		.measure_en, .act_default_mode, .act_timer_zero, .inactivity_flag_timer_zero(1'b0), .irq_pin_a_o,
		.irq_pin_a_oe, .irq_pin_b_o, .irq_pin_b_oe);
	sample_feeder sample_feeder_inst (.clk_sys, .sys_rst, .go, .n_req, .gap, .busy,
		.sample_valid, .sample_data);
	function automatic [11:0] val(input [11:0] n);
		val = 12'h801 + n * 12'h1A3;
	endfunction
	task automatic final_report;
		$display("compared %0d mismatched %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input [7:0] e, input [7:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input [7:0] a, input [7:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input [7:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic rc(input [7:0] a, input [7:0] e);
		rd(a);
		chk($sformatf("reg %h", a), e, d);
	endtask
	// One buffer entry: upper byte, then lower byte
	task automatic ent(input [11:0] v, input s);
		rc(8'h3B, v[11:4]);
		rc(8'h3B, {v[3:0], 3'b000, s});
	endtask
	task automatic pin(input bit sb, input [1:0] e);
		repeat (3) @(posedge clk_sys);
		#1 chk(sb ? "pin b" : "pin a", {6'h00, e}, sb ? {6'h00, irq_pin_b_oe, irq_pin_b_o} :
			{6'h00, irq_pin_a_oe, irq_pin_a_o});
	endtask
	task automatic evt(input bit m);
		@(posedge clk_sys);
		if (m) motion_warn_evt <= 1'b1;
		else activity_evt <= 1'b1;
		@(posedge clk_sys);
		motion_warn_evt <= 1'b0;
		activity_evt <= 1'b0;
	endtask
	// Reconfigure only in standby
	task automatic mode(input [7:0] c);
		@(posedge clk_sys);
		measure_en <= 1'b0;
		wr(8'h3A, 8'h00);
		wr(8'h3A, c);
		measure_en <= 1'b1;
		b = k;
	endtask
	task automatic feed(input [7:0] n);
		@(posedge clk_sys);
		go <= 1'b1;
		n_req <= n;
		@(posedge clk_sys);
		go <= 1'b0;
		for (i = 0; i < 200; i++) begin
			#1;
			if (!busy && !sample_valid) break;
			@(posedge clk_sys);
		end
		if (i == 200) begin
			error_cnt++;
			final_report();
		end
		k = k + n;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial begin
		{sys_rst, reg_wr, reg_rd, go, measure_en, activity_evt, motion_warn_evt} = 7'h40;
		{act_default_mode, act_timer_zero, reg_addr, reg_wdata, n_req} = 26'h0;
		{gap, k, b, error_cnt, n_compared} = 0;
		gap = 4'h1;
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		pin(0, 2'b00);
		pin(1, 2'b00);
		rc(8'h39, 8'h80);
		rc(8'h3A, 8'h00);
		rc(8'h7F, 8'h00);
		rc(8'h3B, 8'h00);
		$display("test reset done");
		wr(8'h39, 8'h03);
		mode(8'h02);
		feed(8'd5);
		rc(8'h04, 8'h07);
		for (int j = 0; j < 5; j++) ent(val(12'(b + j)), j == 0);
		rc(8'h3B, 8'h00);
		rc(8'h04, 8'h07);
		rc(8'h04, 8'h01);
		mode(8'h02);
		feed(8'd10);
		rc(8'h04, 8'h0F);
		for (int j = 2; j < 10; j++) ent(val(12'(b + j)), 1'b0);
		rc(8'h04, 8'h0F);
		rc(8'h04, 8'h01);
		$display("test stream done");
		gap = 4'h3;
		mode(8'h06);
		feed(8'd10);
		rc(8'h04, 8'h0F);
		for (int j = 0; j < 8; j++) ent(val(12'(b + j)), j == 0);
		@(posedge clk_sys) measure_en <= 1'b0;
		wr(8'h3A, 8'h00);
		rc(8'h04, 8'h07);
		wr(8'h39, 8'h00);
		rc(8'h04, 8'h05);
		wr(8'h3A, 8'h01);
		rc(8'h04, 8'h05);
		rc(8'h04, 8'h01);
		wr(8'h39, 8'h02);
		$display("test oldest done");
		gap = 4'h1;
		mode(8'h04);
		feed(8'd4);
		rc(8'h3B, 8'h00);
		evt(0);
		feed(8'd4);
		for (int j = 0; j < 6; j++) ent(val(12'(b + j)), j == 0);
		rc(8'h3B, 8'h00);
		$display("test trigger done");
		wr(8'h3D, 8'h10);
		pin(1, 2'b11);
		rc(8'h05, 8'h02);
		pin(1, 2'b10);
		b = k;
		feed(8'd2);
		evt(0);
		feed(8'd2);
		for (int j = 0; j < 4; j++) ent(val(12'(b + j)), 1'b0);
		rc(8'h05, 8'h02);
		wr(8'h3D, 8'h40);
		evt(1);
		pin(1, 2'b11);
		rc(8'h05, 8'h01);
		pin(1, 2'b10);
		@(posedge clk_sys);
		act_default_mode <= 1'b1;
		act_timer_zero <= 1'b1;
		wr(8'h3D, 8'h10);
		evt(0);
		rc(8'h05, 8'h02);
		pin(1, 2'b11);
		@(posedge clk_sys) measure_en <= 1'b0;
		pin(1, 2'b10);
		wr(8'h3C, 8'h01);
		pin(0, 2'b11);
		rd(8'h08);
		pin(0, 2'b10);
		@(posedge clk_sys) measure_en <= 1'b1;
		feed(8'd1);
		pin(0, 2'b11);
		wr(8'h3C, 8'h81);
		pin(0, 2'b10);
		last_v = val(12'(k - 12'd1));
		rc(8'h08, last_v[11:4]);
		rc(8'h09, {last_v[3:0], 4'h0});
		pin(0, 2'b11);
		$display("test pins done");
		final_report();
	end
endmodule
